// ---- rtl/pmc_top.sv ----
// Power mode sequencer and core/system clock dividers with Wishbone registers.
// Assumes clk_i is the PLL output; clock outputs are one-cycle enables.
// Summary of operation
// R1: Deep sleep stops core and system clock enables.
// R2: Deep sleep blocks asynchronous peripherals from internal resources.
// R3: Deep sleep ends only on reset pin or RTC interrupt.
// R4: RTC interrupt in deep sleep enters active mode with PLL bypassed.
// R5: Reset pin in deep sleep enters full-on mode.
// R6: Hibernate removes core supply and both clocks.
// R7: Hibernate puts all external pins into high impedance.
// R8: Hibernate wakes on CAN, media, keypad, counter, USB, GPIO, RTC, reset.
// R9: Any hibernate wake runs the full hardware reset sequence.
// R10: Only regulator register survives hibernate; all others reset.
// R11: Regulator register sets core voltage in 50 mV steps.
// R12: PLL multiplier from 0.5x to 64x, default 8x.
// R13: Clock output pin carries system clock, enabled by control bit.
// R14: System divider 1 to 15, default 4.
// R15: System divider value is the ratio directly.
// R16: New system divider applies at run time without relock wait.
// R17: Core divider 00/01/10/11 gives 1/2/4/8, default 1.
// R18: Software keeps system clock below its maximum.
// R19: Active mode runs core and system clocks at input clock.
// R20: Sleep wake goes to active if bypassed, else full-on.
// R21: System divider value zero is ignored.
// R22: Divider changes switch only at divided clock boundaries.
//
// The placing of the registers and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
module pmc_top
  import pmc_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // Pins
  input  wire logic              input_clock_i,
  input  wire logic [WAKE_N-1:0] wake_i,
  output logic                   sysclk_output_pin_o,
  output logic                   sysclk_output_pin_oe_n_o,
  // Power and clock control
  output pmc_clk_t               clk_o,
  output logic      [7:0]        pll_mult_o,
  output logic      [7:0]        core_vlevel_o,
  output logic                   core_supply_en_o,
  output logic                   periph_block_o,
  output logic                   pins_hiz_o,
  output logic                   sys_reset_o
);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    return (old & ~m) | (nw & m);
  endfunction

  // Pin synchronisers
  logic [WAKE_N:0]   s1_q;
  logic [WAKE_N:0]   s2_q;
  logic              inclk_q;
  logic [WAKE_N-1:0] wake_s;
  logic              in_tick;

  always_ff @(posedge clk_i) begin
    s1_q    <= {input_clock_i, wake_i};
    s2_q    <= s1_q;
    inclk_q <= s2_q[WAKE_N];
  end
  assign wake_s  = s2_q[WAKE_N-1:0];
  assign in_tick = s2_q[WAKE_N] & ~inclk_q;

  // Registers
  pmc_mode_t   mode_q, mode_d;
  logic        byp_q, off_q, am_q, ack_q;
  logic [7:0]  mul_q, vlvl_q, wen_q;
  logic [3:0]  sys_q, sys_act_q, sc_q;
  logic [1:0]  core_q, core_act_q;
  logic [2:0]  cc_q;
  logic [4:0]  seq_q;
  logic [31:0] dat_q;

  // Bus decode
  logic        req, acc, wr, seq_busy, srst, run;
  logic        hit_pc, hit_dv, hit_vr, hit_am, hit_we, hit_st;
  logic [31:0] pc_w, dv_w, vr_w, am_w, we_w, st_w, rdata;
  logic [31:0] pc_n, dv_n, vr_n, am_n, we_n;
  logic [1:0]  cmd;
  logic [7:0]  mul_n;
  logic [3:0]  sys_n;

  assign req    = wb_cyc_i & wb_stb_i;
  assign acc    = req & ~ack_q;
  // Writes commit on the edge where the master samples ack
  assign wr     = req & ack_q & wb_we_i;
  assign hit_pc = wb_adr_i == OFS_PLL_CTRL;
  assign hit_dv = wb_adr_i == OFS_DIVIDER;
  assign hit_vr = wb_adr_i == OFS_REGULAT;
  assign hit_am = wb_adr_i == OFS_AMG_CTRL;
  assign hit_we = wb_adr_i == OFS_WAKE_EN;
  assign hit_st = wb_adr_i == OFS_STATUS;

  assign pc_w = {16'h0000, mul_q, 6'h00, off_q, byp_q};
  assign dv_w = {26'h0000000, core_q, sys_q};
  assign vr_w = {24'h000000, vlvl_q};
  assign am_w = {31'h00000000, am_q};
  assign we_w = {24'h000000, wen_q};
  assign st_w = {26'h0000000, clk_o.pll_byp, clk_o.pll_en, 1'b0, mode_q};
  assign pc_n = merge(pc_w, wb_dat_i, wb_sel_i);
  assign dv_n = merge(dv_w, wb_dat_i, wb_sel_i);
  assign vr_n = merge(vr_w, wb_dat_i, wb_sel_i);
  assign am_n = merge(am_w, wb_dat_i, wb_sel_i);
  assign we_n = merge(we_w, wb_dat_i, wb_sel_i);
  assign cmd   = pc_n[PC_CMD_LSB +: 2];
  assign mul_n = pc_n[PC_MUL_LSB +: 8];
  assign sys_n = dv_n[DV_SYS_LSB +: 4];

  // Unmapped addresses read zero and are still acknowledged
  assign rdata = hit_pc ? pc_w : hit_dv ? dv_w : hit_vr ? vr_w :
                 hit_am ? am_w : hit_we ? we_w : hit_st ? st_w : 32'h00000000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
    end else begin
      ack_q <= acc;
      if (acc) begin
        dat_q <= rdata;
      end
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // Hibernate wake reset sequence
  assign seq_busy = seq_q != 5'h00;
  assign srst     = rst_i | wake_s[WK_RST] | seq_busy; // R5
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq_q <= 5'h00;
    end else if (mode_q == PM_HIB && |wake_s) begin // R8
      seq_q <= RST_SEQ_LEN; // R9
    end else if (seq_busy) begin
      seq_q <= seq_q - 5'h01;
    end
  end

  // Mode sequencer
  assign run = mode_q == PM_FULL_ON || mode_q == PM_ACTIVE;
  always_comb begin
    mode_d = mode_q;
    unique case (mode_q)
      PM_FULL_ON, PM_ACTIVE: begin
        mode_d = byp_q ? PM_ACTIVE : PM_FULL_ON;
        if (wr && hit_pc) begin
          if (cmd == CMD_SLEEP) mode_d = PM_SLEEP;
          if (cmd == CMD_DEEP) mode_d = PM_DEEP;
          if (cmd == CMD_HIB) mode_d = PM_HIB; // R6
        end
      end
      PM_SLEEP: begin
        if (|(wake_s[WK_RTC:0] & wen_q[WK_RTC:0])) begin
          mode_d = byp_q ? PM_ACTIVE : PM_FULL_ON; // R20
        end
      end
      PM_DEEP: begin
        if (wake_s[WK_RTC]) mode_d = PM_ACTIVE; // R3
      end
      PM_HIB: mode_d = PM_HIB;
    endcase
  end

  // All but the regulator register are cleared by the wake reset
  always_ff @(posedge clk_i) begin
    if (srst) begin
      mode_q <= PM_FULL_ON; // R10
      byp_q  <= 1'b0;
      off_q  <= 1'b0;
      mul_q  <= MUL_RST; // R12
      sys_q  <= SYS_RST; // R14
      core_q <= COR_RST; // R17
      am_q   <= 1'b0; // R13
      wen_q  <= 8'h00;
    end else begin
      mode_q <= mode_d;
      if (wr && hit_pc && run) begin
        off_q <= pc_n[PC_OFF];
        byp_q <= pc_n[PC_BYP];
        if (mul_n != 8'h00 && mul_n <= MUL_MAX) mul_q <= mul_n; // R12
      end
      if (wr && hit_dv) begin
        if (sys_n != 4'h0) sys_q <= sys_n; // R21
        core_q <= dv_n[DV_COR_LSB +: 2];
      end
      if (wr && hit_am) am_q <= am_n[AM_SYSCLK_OUTPUT_PIN];
      if (wr && hit_we) wen_q <= we_n[WAKE_N-1:0];
      // Hardware bypass set wins over software
      if (mode_q == PM_DEEP && wake_s[WK_RTC]) byp_q <= 1'b1; // R4
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vlvl_q <= VLV_RST;
    end else if (wr && hit_vr) begin
      vlvl_q <= vr_n[7:0]; // R11
    end
  end

  // Dividers; a new ratio is taken only on wrap so no pulse is cut short
  logic sc_wrap, cc_wrap, core_en, sys_en, pll_en;
  logic [3:0] sys_half;
  assign sc_wrap  = sc_q == sys_act_q - 4'h1; // R15
  assign cc_wrap  = cc_q == 3'((4'h1 << core_act_q) - 4'h1); // R17
  assign sys_half = 4'((5'(sys_act_q) + 5'h01) >> 1);
  assign core_en  = run; // R1
  assign sys_en   = run || mode_q == PM_SLEEP; // R1
  assign pll_en   = (run || mode_q == PM_SLEEP) && !(mode_q == PM_ACTIVE && off_q);

  always_ff @(posedge clk_i) begin
    if (srst) begin
      sc_q       <= 4'h0;
      cc_q       <= 3'h0;
      sys_act_q  <= SYS_RST;
      core_act_q <= COR_RST;
    end else begin
      sc_q <= sc_wrap ? 4'h0 : sc_q + 4'h1;
      cc_q <= cc_wrap ? 3'h0 : cc_q + 3'h1;
      if (sc_wrap) sys_act_q <= sys_q; // R16
      if (cc_wrap) core_act_q <= core_q; // R22
    end
  end

  // Registered outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_o            <= '0;
      sysclk_output_pin_o         <= 1'b0;
      sysclk_output_pin_oe_n_o    <= 1'b1;
      core_supply_en_o <= 1'b1;
      periph_block_o   <= 1'b0;
      pins_hiz_o       <= 1'b0;
      sys_reset_o      <= 1'b1;
    end else begin
      clk_o.core_tick  <= core_en && (byp_q ? in_tick : cc_wrap); // R19
      clk_o.sys_tick   <= sys_en && (byp_q ? in_tick : sc_wrap); // R19
      clk_o.pll_en     <= pll_en;
      clk_o.pll_byp    <= byp_q;
      // Divide by one cannot be shown at pin rate and reads as high
      sysclk_output_pin_o         <= sys_en && (byp_q ? s2_q[WAKE_N] : sc_q < sys_half); // R13
      sysclk_output_pin_oe_n_o    <= !(am_q && mode_q != PM_HIB); // R7
      core_supply_en_o <= mode_q != PM_HIB; // R6
      periph_block_o   <= mode_q == PM_DEEP || mode_q == PM_HIB; // R2
      pins_hiz_o       <= mode_q == PM_HIB; // R7
      sys_reset_o      <= srst; // R9
    end
  end
  assign pll_mult_o    = mul_q;
  assign core_vlevel_o = vlvl_q;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_deep_clk_off: assert property (mode_q == PM_DEEP |=> !clk_o.core_tick && !clk_o.sys_tick) // R1
    else $error("clock enable while in deep sleep");
  a_deep_block: assert property (mode_q == PM_DEEP |=> periph_block_o) // R2
    else $error("peripherals not blocked in deep sleep");
  a_deep_stay: assert property ((mode_q == PM_DEEP && !wake_s[WK_RTC] && !srst)
      |=> mode_q == PM_DEEP) // R3
    else $error("deep sleep left without cause");
  a_rtc_active: assert property ((mode_q == PM_DEEP && wake_s[WK_RTC] && !srst)
      |=> mode_q == PM_ACTIVE && byp_q) // R4
    else $error("rtc wake not into bypassed active");
  a_pin_fullon: assert property ((mode_q == PM_DEEP && wake_s[WK_RST]) |=> mode_q == PM_FULL_ON) // R5
    else $error("reset pin did not give full-on");
  a_hib_supply: assert property (mode_q == PM_HIB |=> !core_supply_en_o && !clk_o.sys_tick) // R6
    else $error("core supply on in hibernate");
  a_hib_hiz: assert property (mode_q == PM_HIB |=> pins_hiz_o && sysclk_output_pin_oe_n_o) // R7
    else $error("pins driven in hibernate");
  a_hib_reseq: assert property ((mode_q == PM_HIB && |wake_s) |=> ##1 sys_reset_o[*8]) // R9
    else $error("hibernate wake without reset sequence");
  a_vreg_keep: assert property ((seq_busy && !(wr && hit_vr)) |=> $stable(vlvl_q)) // R10
    else $error("regulator lost across hibernate wake");
  a_sys_zero: assert property ((wr && hit_dv && sys_n == 4'h0 && !srst) |=> $stable(sys_q)) // R21
    else $error("zero system divider accepted");
  a_div_boundary: assert property ($changed(sys_act_q) && !$past(srst) |-> $past(sc_wrap)) // R22
    else $error("system ratio changed off boundary");
  a_sleep_wake: assert property ((mode_q == PM_SLEEP && |(wake_s[WK_RTC:0] & wen_q[WK_RTC:0]) && !srst)
      |=> mode_q == ($past(byp_q) ? PM_ACTIVE : PM_FULL_ON)) // R20
    else $error("wrong mode after sleep wake");

  c_rtc_wake: cover property (mode_q == PM_DEEP ##1 mode_q == PM_ACTIVE);
  c_sleep_wake: cover property (mode_q == PM_SLEEP ##1 mode_q == PM_FULL_ON);
  c_hib_wake: cover property (mode_q == PM_HIB ##1 seq_busy);
  c_ratio_change: cover property ($changed(sys_act_q));

endmodule

// ---- rtl/pmc_pkg.sv ----
// Constants, types and register map of the power mode and clock divider block.
// Assumes a classic Wishbone slave with 8-bit byte addresses and 32-bit data.
package pmc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_PLL_CTRL = 8'h00;
  localparam logic [7:0] OFS_DIVIDER  = 8'h04;
  localparam logic [7:0] OFS_REGULAT  = 8'h08;
  localparam logic [7:0] OFS_AMG_CTRL = 8'h0C;
  localparam logic [7:0] OFS_WAKE_EN  = 8'h10;
  localparam logic [7:0] OFS_STATUS   = 8'h14;
  // Field positions
  localparam int PC_BYP     = 0;
  localparam int PC_OFF     = 1;
  localparam int PC_MUL_LSB = 8;
  localparam int PC_CMD_LSB = 16;
  localparam int DV_SYS_LSB = 0;
  localparam int DV_COR_LSB = 4;
  localparam int AM_SYSCLK_OUTPUT_PIN  = 0;
  localparam int ST_PLL_EN  = 4;
  localparam int ST_BYP     = 5;
  // Reset values, multiplier limit and regulator step
  localparam logic [7:0] MUL_RST = 8'h10;
  localparam logic [7:0] MUL_MAX = 8'h80;
  localparam logic [3:0] SYS_RST = 4'h4;
  localparam logic [1:0] COR_RST = 2'h0;
  localparam logic [7:0] VLV_RST = 8'h10;
  localparam int VR_STEP_MV = 50;
  // Wake source bit positions
  localparam int WAKE_N = 8;
  localparam int WK_RTC = 6;
  localparam int WK_RST = 7;
  // Hardware reset sequence length in clocks
  localparam logic [4:0] RST_SEQ_LEN = 5'h10;
  // Mode commands
  localparam logic [1:0] CMD_SLEEP = 2'h1;
  localparam logic [1:0] CMD_DEEP  = 2'h2;
  localparam logic [1:0] CMD_HIB   = 2'h3;
  typedef enum logic [2:0] {PM_FULL_ON, PM_ACTIVE, PM_SLEEP, PM_DEEP, PM_HIB} pmc_mode_t;
  typedef struct packed {
    logic core_tick;
    logic sys_tick;
    logic pll_en;
    logic pll_byp;
  } pmc_clk_t;
endpackage

// ---- verification/pmc_wake_model.sv ----
// Wake source pins and input clock pin as seen by the block.
// Assumes the bench asks for wake levels; the input clock runs free.
`timescale 1ns/1ps
module pmc_wake_model (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Requests from the bench
  input  wire logic [7:0] req_i,
  // Pins
  output logic            input_clock_o,
  output logic [7:0]      wake_o
);
  logic [1:0] div_q = 2'h0;
  // Oscillator never halts, not even in reset
  always_ff @(posedge clk_i) begin
    div_q <= div_q + 2'h1;
  end
  assign input_clock_o = div_q[1];
  // Wake levels stand until the bench drops them
  always_ff @(posedge clk_i) begin
    wake_o <= rst_i ? 8'h00 : req_i;
  end
endmodule

// ---- verification/test_pmc_top.sv ----
// Self-checking bench of the power mode and clock divider block.
// Assumes pmc_pkg is compiled first; wake pins come from the wake model.
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch %s exp %0h got %0h", n, e, g); end end
module test_pmc_top;
  import pmc_pkg::*;
  logic        clk_i = 0;
  logic        rst_i = 1;
  logic        wb_cs = 0;
  logic        wb_we = 0;
  logic [7:0]  wb_adr = 8'h00;
  logic [31:0] wb_wdat = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [7:0]  req = 8'h00;
  logic [7:0]  wake;
  logic        in_clk;
  logic        oe_n;
  logic        sysclk_output_pin;
  pmc_clk_t    clk_o;
  logic [7:0]  mult;
  logic [7:0]  vlev;
  logic        sup_en;
  logic        blk;
  logic        hiz;
  logic        sys_rst;
  logic [31:0] r;
  int          bad_count = 0;
  int          num_checks = 0;
  int          g;

  pmc_top i_pmc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cs), .wb_stb_i(wb_cs),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .input_clock_i(in_clk), .wake_i(wake),
    .sysclk_output_pin_o(sysclk_output_pin), .sysclk_output_pin_oe_n_o(oe_n), .clk_o(clk_o), .pll_mult_o(mult),
    .core_vlevel_o(vlev), .core_supply_en_o(sup_en), .periph_block_o(blk),
    .pins_hiz_o(hiz), .sys_reset_o(sys_rst));
  pmc_wake_model i_pmc_wake_model (.clk_i(clk_i), .rst_i(rst_i), .req_i(req),
    .input_clock_o(in_clk), .wake_o(wake));

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task tk(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // A wait that runs out of its bound counts as a mismatch and ends the run
  task lim(input int i, input int n);
    if (i >= n) begin
      bad_count++;
      wrap_up;
    end
  endtask

  // Wake levels stand eight cycles, changed only at a rising edge
  task pulse(input logic [7:0] v);
    @(posedge clk_i);
    req <= v;
    repeat (8) @(posedge clk_i);
    req <= 8'h00;
  endtask

  // Classic single cycle; request held until ack is seen at an edge
  task wb(input bit w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    wb_cs <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_wdat <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    r = wb_dat_o;
    wb_cs <= 1'b0;
    wb_we <= 1'b0;
    lim(i, 20);
  endtask

  // Cycles between two ticks of the core or the system enable
  task gap(input bit c);
    int i;
    // Look off the edge so the ticks have settled
    tk(0);
    for (i = 0; i < 40 && (c ? clk_o.core_tick : clk_o.sys_tick) !== 1'b1; i++) tk(1);
    lim(i, 40);
    tk(1);
    for (g = 1; g < 40 && (c ? clk_o.core_tick : clk_o.sys_tick) !== 1'b1; g++) tk(1);
    lim(g, 40);
  endtask

  task quiet(input bit c);
    int i;
    g = 0;
    for (i = 0; i < 30; i++) begin
      tk(1);
      if (clk_o.sys_tick === 1'b1 && !c) g++;
      if (clk_o.core_tick === 1'b1) g++;
    end
  endtask

  task t_reset;
    int i;
    `CHK("oe_n", 1'b1, oe_n)
    wb(0, OFS_DIVIDER, 0);
    `CHK("div", 32'h04, r)
    wb(0, OFS_PLL_CTRL, 0);
    `CHK("pll", 32'h1000, r)
    wb(0, 8'h20, 0);
    `CHK("unmapped", 32'h0, r)
    wb(1, OFS_PLL_CTRL, 32'h8000);
    tk(1);
    `CHK("mult max", 8'h80, mult)
    wb(1, OFS_PLL_CTRL, 32'h8100);
    tk(1);
    `CHK("mult over", 8'h80, mult)
    wb(1, OFS_PLL_CTRL, 32'h0100);
    tk(1);
    `CHK("mult min", 8'h01, mult)
    wb(1, OFS_PLL_CTRL, 32'h1000);
    wb(1, OFS_AMG_CTRL, 32'h1);
    tk(1);
    `CHK("oe_n on", 1'b0, oe_n)
    // Ratio 4: pin high two counts of four, twenty cycles span whole periods
    g = 0;
    for (i = 0; i < 20; i++) begin
      tk(1);
      if (sysclk_output_pin === 1'b1) g++;
    end
    `CHK("sysclk_output_pin duty", 10, g)
    $display("test reset done");
  endtask

  task t_div;
    int s;
    gap(0);
    `CHK("sys 4", 4, g)
    for (s = 1; s < 16; s += 9) begin
      wb(1, OFS_DIVIDER, s);
      gap(0);
      gap(0);
      `CHK("sys ratio", s, g)
    end
    wb(1, OFS_DIVIDER, 32'h2);
    gap(0);
    gap(0);
    `CHK("sys 2", 2, g)
    wb(1, OFS_DIVIDER, 32'hA);
    wb(1, OFS_DIVIDER, 32'h0);
    gap(0);
    gap(0);
    `CHK("sys zero", 10, g)
    for (s = 0; s < 4; s++) begin
      wb(1, OFS_DIVIDER, 32'h4 | (s << 4));
      gap(1);
      gap(1);
      `CHK("core ratio", 1 << s, g)
    end
    $display("test dividers done");
  endtask

  task t_sleep;
    wb(1, OFS_WAKE_EN, 32'h01);
    wb(1, OFS_PLL_CTRL, 32'h11000);
    quiet(1);
    `CHK("sleep core", 0, g)
    pulse(8'h01);
    wb(0, OFS_STATUS, 0);
    `CHK("sleep wake", 3'h0, r[2:0])
    $display("test sleep done");
  endtask

  task t_deep;
    // Ratios unlike the input clock period, so bypass shows in the gaps
    wb(1, OFS_DIVIDER, 32'h2);
    wb(1, OFS_PLL_CTRL, 32'h21000);
    tk(2);
    `CHK("block", 1'b1, blk)
    quiet(0);
    `CHK("deep ticks", 0, g)
    pulse(8'h3F & ~8'h40);
    wb(0, OFS_STATUS, 0);
    `CHK("deep stay", 3'h3, r[2:0])
    pulse(8'h40);
    wb(0, OFS_STATUS, 0);
    `CHK("deep rtc", 3'h1, r[2:0])
    `CHK("bypass", 1'b1, clk_o.pll_byp)
    `CHK("pll on", 1'b1, clk_o.pll_en)
    gap(0);
    `CHK("byp sys", 4, g)
    gap(1);
    `CHK("byp core", 4, g)
    // Bypass left set: the reset pin must still give full-on
    wb(1, OFS_PLL_CTRL, 32'h21001);
    pulse(8'h80);
    wb(0, OFS_STATUS, 0);
    `CHK("deep pin", 3'h0, r[2:0])
    `CHK("pin byp", 1'b0, r[5])
    $display("test deep done");
  endtask

  task t_hib;
    int i;
    wb(1, OFS_REGULAT, 32'h22);
    wb(1, OFS_DIVIDER, 32'h7);
    wb(1, OFS_PLL_CTRL, 32'h31000);
    tk(2);
    `CHK("supply", 1'b0, sup_en)
    `CHK("hiz", 1'b1, hiz)
    quiet(0);
    `CHK("hib ticks", 0, g)
    pulse(8'h04);
    for (i = 0; i < 40 && sys_rst !== 1'b1; i++) tk(1);
    `CHK("hw reset", 1'b1, sys_rst)
    for (i = 0; i < 40 && sys_rst !== 1'b0; i++) tk(1);
    lim(i, 40);
    wb(0, OFS_REGULAT, 0);
    `CHK("reg kept", 32'h22, r)
    `CHK("vlevel", 8'h22, vlev)
    wb(0, OFS_DIVIDER, 0);
    `CHK("div lost", 32'h04, r)
    `CHK("supply on", 1'b1, sup_en)
    $display("test hibernate done");
  endtask

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    tk(4);
    t_reset;
    t_div;
    t_sleep;
    t_deep;
    t_hib;
    wrap_up;
  end
endmodule
